/* File: pkg/byte_alu_pkg.sv */
// Constants, types and the register map of the byte ALU slice.
// Assumes one clock domain and a 32-bit AHB-Lite register bus.
package byte_alu_pkg;

   // Register map, byte addresses within the slave window
   localparam int              ADDR_W       = 12;
   localparam logic [11:0]     OFF_CMD      = 12'h000;
   localparam logic [11:0]     OFF_ACC      = 12'h004;
   localparam logic [11:0]     OFF_STATUS   = 12'h008;
   localparam logic [11:0]     OFF_RESULT   = 12'h00c;
   localparam logic [11:0]     OFF_OPCOUNT  = 12'h010;
   // File registers: one word each from this base, index in bits 8:2
   localparam logic [2:0]      FILE_SEL     = 3'h1;
   localparam int              FILE_SEL_LSB = 9;
   localparam int              FILE_IDX_LSB = 2;

   // Widths
   localparam int              DATA_W       = 8;
   localparam int              FADDR_W      = 7;
   localparam int              FILE_DEPTH   = 128;
   localparam int              OPCOUNT_W    = 16;

   // Reset values
   localparam logic [7:0]      ACC_RESET    = 8'h00;
   localparam logic [7:0]      RESULT_RESET = 8'h00;
   localparam logic [15:0]     COUNT_RESET  = 16'h0000;

   // Destination bit values
   localparam logic            DEST_ACC     = 1'b0;
   localparam logic            DEST_FILE    = 1'b1;

   // AHB transfer type bit that marks NONSEQ or SEQ
   localparam int              HTRANS_ACT   = 1;
   localparam logic            HRESP_OKAY   = 1'b0;

   typedef enum logic [2:0] {
      op_idle                     = 3'b000,
      op_literal_minus_accumulator = 3'b001,
      op_file_minus_accumulator   = 3'b010,
      op_xor_literal_into_acc     = 3'b011,
      op_xor_acc_with_file        = 3'b100,
      op_nibble_exchange_file     = 3'b101
   } alu_op_t;

   // Status register layout: carry bit 0, half carry bit 1, zero bit 2
   typedef struct packed {
      logic zero;
      logic half_carry_flag;
      logic carry;
   } flags_t;

   localparam flags_t          FLAGS_RESET  = 3'h0;
   localparam int              FLAGS_W      = 3;

   // Command word: op bits 2:0, file address 9:3, dest 10, literal 18:11
   typedef struct packed {
      logic [7:0] literal;
      logic       dest;
      logic [6:0] faddr;
      alu_op_t    op;
   } cmd_t;

   localparam int              CMD_W        = 19;
   localparam cmd_t            CMD_RESET    = 19'h00000;

   typedef struct packed {
      logic [7:0] result;
      flags_t     flags;
      logic       upd_carries;
      logic       upd_zero;
      logic       to_file;
      logic       valid;
   } alu_out_t;

   typedef enum logic {
      bus_idle      = 1'b0,
      bus_read_wait = 1'b1
   } bus_state_t;

endpackage

/* File: rtl/file_store.sv */
// File register array: one write port, two asynchronous read ports.
// Assumes the caller never asks for two writes in one cycle.
module file_store
   import byte_alu_pkg::*;
#(
   parameter int WIDTH = DATA_W,
   parameter int DEPTH = FILE_DEPTH,
   parameter int AW    = FADDR_W
) (
   input  wire logic             hclk,
   input  wire logic             ce,
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]    raddr_a,
   output logic      [WIDTH-1:0] rdata_a,
   input  wire logic [AW-1:0]    raddr_b,
   output logic      [WIDTH-1:0] rdata_b
);

   logic [WIDTH-1:0] mem [DEPTH];

   // Contents are data, not control, so they carry no reset
   always_ff @(posedge hclk) begin
      if (ce && we) begin
         mem[waddr] <= wdata;
      end
   end

   // Port a serves the bus, port b the ALU operand
   assign rdata_a = mem[raddr_a];
   assign rdata_b = mem[raddr_b];

endmodule // file_store

/* File: rtl/alu_compute.sv */
// Combinational ALU for subtract, exclusive-or and nibble swap.
// Assumes operands are stable during the executing cycle.
module alu_compute
   import byte_alu_pkg::*;
(
   input  wire alu_op_t    op,
   input  wire logic       dest,
   input  wire logic [7:0] acc,
   input  wire logic [7:0] fval,
   input  wire logic [7:0] literal,
   output alu_out_t        out
);

   // Minuend minus accumulator, with borrow-style carry and half carry
   function automatic logic [9:0] subtract(input logic [7:0] a, input logic [7:0] w);
      logic [7:0] diff;
      diff = 8'(a - w);
      return {diff, (w <= a), (w[3:0] <= a[3:0])};
   endfunction

   function automatic logic is_zero(input logic [7:0] v);
      return (v == 8'h00);
   endfunction

   logic [9:0] sub_lit;
   logic [9:0] sub_file;

   assign sub_lit  = subtract(literal, acc);
   assign sub_file = subtract(fval, acc);

   // Result, flag values and which flags the op may touch
   always_comb begin
      out = '0;
      case (op)
         op_literal_minus_accumulator: begin
            out.result                = sub_lit[9:2];
            out.flags.carry           = sub_lit[1];
            out.flags.half_carry_flag = sub_lit[0];
            out.upd_carries           = 1'b1;
            out.upd_zero              = 1'b1;
            out.to_file               = DEST_ACC;
            out.valid                 = 1'b1;
         end
         op_file_minus_accumulator: begin
            out.result                = sub_file[9:2];
            out.flags.carry           = sub_file[1];
            out.flags.half_carry_flag = sub_file[0];
            out.upd_carries           = 1'b1;
            out.upd_zero              = 1'b1;
            out.to_file               = (dest == DEST_FILE);
            out.valid                 = 1'b1;
         end
         op_xor_literal_into_acc: begin
            out.result   = acc ^ literal;
            out.upd_zero = 1'b1;
            out.to_file  = DEST_ACC;
            out.valid    = 1'b1;
         end
         op_xor_acc_with_file: begin
            out.result   = acc ^ fval;
            out.upd_zero = 1'b1;
            out.to_file  = (dest == DEST_FILE);
            out.valid    = 1'b1;
         end
         op_nibble_exchange_file: begin
            out.result  = {fval[3:0], fval[7:4]};
            out.to_file = (dest == DEST_FILE);
            out.valid   = 1'b1;
         end
         default: begin
            out = '0;
         end
      endcase
      // Zero flag follows the result whenever it is updated
      out.flags.zero = is_zero(out.result);
   end

endmodule // alu_compute

/* File: rtl/byte_alu_sub_xor_swap.sv */
// Byte ALU slice with accumulator, status flags and file registers,
// reached over an AHB-Lite slave port.
// Assumes a single AHB-Lite master, word transfers, one clock domain.
// Register offsets and the command word layout live in the package.
//
// Behaviour
// - Literal minus accumulator, two's complement, result into accumulator.
// - Subtracts: carry clears when accumulator operand is larger, half carry when its low nibble is larger.
// - File minus accumulator updates carry, half carry and zero flags.
// - Destination bit 0 writes accumulator, 1 writes the addressed file register.
// - Xor literal into accumulator, only zero flag updated.
// - Nibble exchange of file register, destination bit chooses, flags unchanged.
// - Xor accumulator with file, destination bit routes, only zero flag.
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
module byte_alu_sub_xor_swap
   import byte_alu_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   output logic [7:0]       acc,
   output flags_t           status_flags
);

   // Address phase capture
   logic [11:0]             addr_q;
   logic                    wr_pend;
   bus_state_t              bus_state;

   // Block state
   cmd_t                    last_cmd;
   logic [7:0]              result;
   logic [OPCOUNT_W-1:0]    opcount;

   // Next values
   logic [7:0]              next_acc;
   logic [OPCOUNT_W-1:0]    next_opcount;
   flags_t                  next_flags;

   // Decode and datapath nets
   logic                    take;
   logic                    do_write;
   logic                    wr_cmd;
   logic                    wr_acc;
   logic                    wr_status;
   logic                    wr_file;
   logic                    exec;
   logic                    read_req;

   // Datapath nets
   cmd_t                    cmd_in;
   alu_out_t                alu_out;
   logic [7:0]              file_rd_bus;
   logic [7:0]              file_rd_alu;
   logic                    file_we;
   logic [FADDR_W-1:0]      file_waddr;
   logic [7:0]              file_wdata;
   logic [31:0]             read_value;

   // True when the captured address falls in the file register window
   function automatic logic in_file_window(input logic [11:0] a);
      return (a[11:FILE_SEL_LSB] == FILE_SEL);
   endfunction

   // Register hit on a whole word, low address bits ignored
   function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] off);
      return (a[11:2] == off[11:2]);
   endfunction

   // Zero-extend a byte register to a bus word
   function automatic logic [31:0] widen_byte(input logic [7:0] v);
      return {24'h00_0000, v};
   endfunction

   // A transfer is taken only while the bus is ready; hsize is not
   // checked, since the master issues only word transfers
   assign take     = hsel && htrans[HTRANS_ACT] && hready;
   assign do_write = wr_pend && hready;
   assign read_req = take && !hwrite;

   // Write strobes, valid in the write data phase
   assign wr_cmd    = do_write && reg_hit(addr_q, OFF_CMD);
   assign wr_acc    = do_write && reg_hit(addr_q, OFF_ACC);
   assign wr_status = do_write && reg_hit(addr_q, OFF_STATUS);
   assign wr_file   = do_write && in_file_window(addr_q);

   // The command runs in the very cycle its word arrives,
   // so a read right behind it already sees the effect
   assign cmd_in = cmd_t'(hwdata[CMD_W-1:0]);
   assign exec   = wr_cmd && alu_out.valid;

   file_store #(
      .WIDTH (DATA_W),
      .DEPTH (FILE_DEPTH),
      .AW    (FADDR_W)
   ) u_file (
      .hclk    (hclk),
      .ce      (ce),
      .we      (file_we),
      .waddr   (file_waddr),
      .wdata   (file_wdata),
      .raddr_a (addr_q[FILE_IDX_LSB +: FADDR_W]),
      .rdata_a (file_rd_bus),
      .raddr_b (cmd_in.faddr),
      .rdata_b (file_rd_alu)
   );

   alu_compute u_alu (
      .op      (cmd_in.op),
      .dest    (cmd_in.dest),
      .acc     (acc),
      .fval    (file_rd_alu),
      .literal (cmd_in.literal),
      .out     (alu_out)
   );

   // File write port: bus writes and ALU write-back never coincide,
   // since both need their own write data phase
   always_comb begin
      file_we    = 1'b0;
      file_waddr = addr_q[FILE_IDX_LSB +: FADDR_W];
      file_wdata = hwdata[7:0];
      if (exec && alu_out.to_file) begin
         file_we    = 1'b1;
         file_waddr = cmd_in.faddr;
         file_wdata = alu_out.result;
      end else if (wr_file) begin
         file_we = 1'b1;
      end
   end

   // Accumulator next value
   always_comb begin
      next_acc = acc;
      if (exec && !alu_out.to_file) begin
         next_acc = alu_out.result;
      end else if (wr_acc) begin
         next_acc = hwdata[7:0];
      end
   end

   // Flags next value: each op touches only its own flags
   always_comb begin
      next_flags = status_flags;
      if (wr_status) begin
         next_flags = flags_t'(hwdata[FLAGS_W-1:0]);
      end
      if (exec && alu_out.upd_carries) begin
         next_flags.carry           = alu_out.flags.carry;
         next_flags.half_carry_flag = alu_out.flags.half_carry_flag;
      end
      if (exec && alu_out.upd_zero) begin
         next_flags.zero = alu_out.flags.zero;
      end
   end

   // Executed-op count next value; wraps at the counter width
   always_comb begin
      next_opcount = opcount;
      if (exec) begin
         next_opcount = OPCOUNT_W'(opcount + 1'b1);
      end
   end

   // Address phase register; a stalled read keeps its address for
   // the read mux and the file port during the wait cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q <= 12'h000;
      end else if (ce && hready) begin
         addr_q <= haddr[11:0];
      end
   end

   // Write pending flag; a read never leaves one behind
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
      end else if (ce && hready) begin
         wr_pend <= take && hwrite;
      end
   end

   // Accumulator; bus writes and command results arrive in
   // different data phases, so they never compete
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc <= ACC_RESET;
      end else if (ce) begin
         acc <= next_acc;
      end
   end

   // Status flags, written whole by software or in part by an op
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_flags <= FLAGS_RESET;
      end else if (ce) begin
         status_flags <= next_flags;
      end
   end

   // Last command word, kept even when its op does nothing, so
   // software can see what was asked
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_cmd <= CMD_RESET;
      end else if (ce && wr_cmd) begin
         last_cmd <= cmd_in;
      end
   end

   // Result of the last executed op, whatever its destination
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         result <= RESULT_RESET;
      end else if (ce && exec) begin
         result <= alu_out.result;
      end
   end

   // Executed-op count; it wraps, so software reads differences
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         opcount <= COUNT_RESET;
      end else if (ce) begin
         opcount <= next_opcount;
      end
   end

   // Read mux; unmapped words read as zero, upper bits always zero
   always_comb begin
      read_value = 32'h0000_0000;
      if (in_file_window(addr_q)) begin
         read_value = widen_byte(file_rd_bus);
      end else if (reg_hit(addr_q, OFF_CMD)) begin
         read_value = {13'h0000, last_cmd};
      end else if (reg_hit(addr_q, OFF_ACC)) begin
         read_value = widen_byte(acc);
      end else if (reg_hit(addr_q, OFF_STATUS)) begin
         read_value = {29'h0000_0000, status_flags};
      end else if (reg_hit(addr_q, OFF_RESULT)) begin
         read_value = widen_byte(result);
      end else if (reg_hit(addr_q, OFF_OPCOUNT)) begin
         read_value = {16'h0000, opcount};
      end
   end

   // Read wait state: hrdata must come from a flop, so every read
   // costs one extra cycle with hreadyout low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_state <= bus_idle;
      end else if (ce) begin
         case (bus_state)
            bus_idle: begin
               if (read_req) begin
                  bus_state <= bus_read_wait;
               end
            end
            bus_read_wait: begin
               bus_state <= bus_idle;
            end
            default: begin
               bus_state <= bus_idle;
            end
         endcase
      end
   end

   // Ready drops for exactly the one wait cycle of each read; a
   // write never waits, since its data lands at the edge ending it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
      end else if (ce) begin
         hreadyout <= !(bus_state == bus_idle && read_req);
      end
   end

   // Read data register; it holds until the next read completes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (ce && bus_state == bus_read_wait) begin
         hrdata <= read_value;
      end
   end

   // Every transfer completes OKAY; no error response exists
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= HRESP_OKAY;
      end else if (ce) begin
         hresp <= HRESP_OKAY;
      end
   end

endmodule // byte_alu_sub_xor_swap

/* File: verif/alu_properties.sv */
// Port-level checks on the byte ALU slice.
// Assumes word transfers and hready fed from hreadyout.
module alu_properties
   import byte_alu_pkg::*;
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        ce,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [7:0]  acc,
   input wire flags_t      status_flags
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       cmd_dp;
   logic       take;
   logic       exec;
   logic [2:0] op;
   logic       dst;
   logic [7:0] lit;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Accepted address phase, and a command data phase ending now
   assign take = hsel && htrans[HTRANS_ACT] && hready && ce;
   assign exec = cmd_dp && ce && hreadyout;
   assign op   = hwdata[2:0];
   assign dst  = hwdata[10];
   assign lit  = hwdata[18:11];

   // Carry a command write over to its data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         cmd_dp <= 1'b0;
      else if (ce && hready)
         cmd_dp <= take && hwrite && haddr[11:0] == OFF_CMD;
   end

   // A read stalls exactly one cycle
   sequence read_wait;
      !hreadyout ##1 hreadyout;
   endsequence

   read_one_wait_a:
      assert property (take && !hwrite |=> read_wait)
      else $error("read wait state wrong");
   lit_sub_a:
      assert property (exec && op == 3'h1 |=> acc == 8'($past(lit) - $past(acc)))
      else $error("literal subtract result wrong");
   sub_borrow_a:
      assert property (exec && op == 3'h1 |=> status_flags.carry == ($past(acc) <= $past(lit))
         && status_flags.half_carry_flag == ($past(acc[3:0]) <= $past(lit[3:0])))
      else $error("subtract carries wrong");
   file_sub_a:
      assert property (exec && op == 3'h2 && !dst
         |=> status_flags.carry == ($past(acc) <= 8'(acc + $past(acc))))
      else $error("file subtract carry wrong");
   dest_file_a:
      assert property (exec && dst && op inside {3'h2, 3'h4, 3'h5} |=> $stable(acc))
      else $error("accumulator changed on file destination");
   xor_lit_a:
      assert property (exec && op == 3'h3
         |=> acc == ($past(acc) ^ $past(lit)) && $stable(status_flags[1:0]))
      else $error("xor literal wrong");
   swap_flags_a:
      assert property (exec && op == 3'h5 |=> $stable(status_flags))
      else $error("swap changed flags");
   xor_file_a:
      assert property (exec && op == 3'h4 |=> $stable(status_flags[1:0]))
      else $error("xor file touched carries");
   zero_flag_a:
      assert property (exec && (op inside {3'h1, 3'h3} || (op inside {3'h2, 3'h4} && !dst))
         |=> status_flags.zero == (acc == 8'h00))
      else $error("zero flag wrong");
endmodule // alu_properties

bind byte_alu_sub_xor_swap alu_properties u_props (.hclk, .hresetn, .ce, .hsel, .haddr,
   .htrans, .hwrite, .hwdata, .hready, .hreadyout, .acc, .status_flags);

/* File: verif/ahb_master_model.sv */
// Bus master standing in for the core side of the slice.
// Assumes one slave whose hreadyout comes back as hready.
module ahb_master_model (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        start,
   input  wire logic        wr,
   input  wire logic [31:0] addr,
   input  wire logic [31:0] wdata,
   output logic             done,
   output logic [31:0]      rdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [1:0] phase;

   // One single word at a time; released data lines flip so stale data never matches
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase  <= 2'h0;
         done   <= 1'b0;
         hsel   <= 1'b0;
         htrans <= 2'h0;
         haddr  <= 32'h0;
         hwrite <= 1'b0;
         hsize  <= 3'h2;
         hwdata <= 32'h0;
         rdata  <= 32'h0;
      end else begin
         done <= 1'b0;
         case (phase)
            2'h0: if (start) begin
               hsel   <= 1'b1;
               htrans <= 2'h2;
               haddr  <= addr;
               hwrite <= wr;
               phase  <= 2'h1;
            end
            2'h1: if (hready) begin
               hsel   <= 1'b0;
               htrans <= 2'h0;
               hwdata <= wdata;
               phase  <= 2'h2;
            end
            default: if (hready) begin
               rdata  <= hrdata;
               done   <= 1'b1;
               hwdata <= ~hwdata;
               phase  <= 2'h0;
            end
         endcase
      end
   end
endmodule // ahb_master_model

/* File: verif/byte_alu_sub_xor_swap_test.sv */
// Self-checking bench for the byte ALU slice.
// Assumes the bus model above and the bound checker.
module byte_alu_sub_xor_swap_test import byte_alu_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [2:0] op;
      logic       dst;
      logic [6:0] fa;
      logic [7:0] lit;
      logic [7:0] a0;
      logic [7:0] f0;
      logic [2:0] s0;
      logic [7:0] ea;
      logic [7:0] ef;
      logic [2:0] es;
   } row_t;

   // op dst fa lit acc file status -> acc file status
   row_t rows[14] = '{
      '{3'h1, 1'h0, 7'h00, 8'h05, 8'h03, 8'h11, 3'h0, 8'h02, 8'h11, 3'h3},
      '{3'h1, 1'h0, 7'h00, 8'h03, 8'h05, 8'h11, 3'h7, 8'hfe, 8'h11, 3'h0},
      '{3'h1, 1'h1, 7'h00, 8'h42, 8'h42, 8'h11, 3'h0, 8'h00, 8'h11, 3'h7},
      '{3'h1, 1'h0, 7'h00, 8'h10, 8'h01, 8'h11, 3'h0, 8'h0f, 8'h11, 3'h1},
      '{3'h2, 1'h0, 7'h7f, 8'h00, 8'h20, 8'h50, 3'h0, 8'h30, 8'h50, 3'h3},
      '{3'h2, 1'h1, 7'h40, 8'h00, 8'h0f, 8'h08, 3'h7, 8'h0f, 8'hf9, 3'h0},
      '{3'h2, 1'h1, 7'h05, 8'h00, 8'h33, 8'h33, 3'h0, 8'h33, 8'h00, 3'h7},
      '{3'h3, 1'h0, 7'h00, 8'hff, 8'h0f, 8'h11, 3'h3, 8'hf0, 8'h11, 3'h3},
      '{3'h3, 1'h0, 7'h00, 8'h5a, 8'h5a, 8'h11, 3'h0, 8'h00, 8'h11, 3'h4},
      '{3'h4, 1'h0, 7'h01, 8'h00, 8'haa, 8'h55, 3'h7, 8'hff, 8'h55, 3'h3},
      '{3'h4, 1'h1, 7'h02, 8'h00, 8'h3c, 8'h3c, 3'h0, 8'h3c, 8'h00, 3'h4},
      '{3'h5, 1'h0, 7'h03, 8'h00, 8'h00, 8'ha5, 3'h5, 8'h5a, 8'ha5, 3'h5},
      '{3'h5, 1'h1, 7'h7e, 8'h00, 8'h77, 8'h0f, 3'h2, 8'h77, 8'hf0, 3'h2},
      '{3'h7, 1'h0, 7'h04, 8'h99, 8'h9a, 8'h12, 3'h2, 8'h9a, 8'h12, 3'h2}};

   logic        hclk;
   logic        hresetn;
   logic        ce;
   logic        start;
   logic        wr;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic        done;
   logic [31:0] rdata;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic [7:0]  acc;
   flags_t      status_flags;
   int          err_total;
   int          comparisons;
   row_t        r;

   byte_alu_sub_xor_swap u_dut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .acc, .status_flags);

   ahb_master_model u_bus (.hclk, .hresetn, .start, .wr, .addr, .wdata, .done, .rdata,
      .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata);

   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   task automatic final_report();
      if (err_total == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One bus transfer; a hung slave ends the run
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      start <= 1'b1;
      wr    <= w;
      addr  <= a;
      wdata <= d;
      @(posedge hclk);
      start <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 50) begin
         @(posedge hclk);
         n++;
      end
      if (done !== 1'b1) begin
         err_total++;
         final_report();
      end
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rdata, exp);
      chk({31'h0, hresp}, 32'h0);
   endtask

   initial begin
      hresetn = 1'b0;
      ce = 1'b1;
      start = 1'b0;
      wr = 1'b0;
      addr = 32'h0;
      wdata = 32'h0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // Reset state, then unmapped places read zero
      chk({24'h0, acc}, 32'h0);
      chk({29'h0, status_flags}, 32'h0);
      rd(32'(OFF_RESULT), 32'h0);
      rd(32'(OFF_OPCOUNT), 32'h0);
      xfer(1'b1, 32'h100, 32'h5a);
      rd(32'h100, 32'h0);
      foreach (rows[i]) begin
         r = rows[i];
         xfer(1'b1, 32'(OFF_ACC), {24'h0, r.a0});
         xfer(1'b1, 32'(OFF_STATUS), {29'h0, r.s0});
         xfer(1'b1, {20'h0, FILE_SEL, r.fa, 2'h0}, {24'h0, r.f0});
         xfer(1'b1, 32'(OFF_CMD), {13'h0, r.lit, r.dst, r.fa, r.op});
         chk({24'h0, acc}, {24'h0, r.ea});
         rd(32'(OFF_STATUS), {29'h0, r.es});
         rd({20'h0, FILE_SEL, r.fa, 2'h0}, {24'h0, r.ef});
      end
      // Two commands with a result read between: zero literal wraps, then xor clears to zero
      xfer(1'b1, 32'(OFF_ACC), 32'h1);
      xfer(1'b1, 32'(OFF_CMD), 32'h1);
      rd(32'(OFF_RESULT), 32'hff);
      xfer(1'b1, 32'(OFF_CMD), {13'h0, 8'hff, 8'h0, 3'h3});
      rd(32'(OFF_ACC), 32'h0);
      rd(32'(OFF_STATUS), 32'h4);
      // Read-back words: last command, its result, executed ops
      rd(32'(OFF_CMD), 32'h0007_f803);
      rd(32'(OFF_RESULT), 32'h0);
      rd(32'(OFF_OPCOUNT), 32'hf);
      // Clock enable low: a write in that time is lost, state frozen
      ce <= 1'b0;
      xfer(1'b1, 32'(OFF_ACC), 32'h55);
      ce <= 1'b1;
      rd(32'(OFF_ACC), 32'h0);
      // Reset again in mid-run
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk({24'h0, acc}, 32'h0);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(32'(OFF_STATUS), 32'h0);
      rd(32'(OFF_OPCOUNT), 32'h0);
      final_report();
   end
endmodule // byte_alu_sub_xor_swap_test
